// *** design/nibble_xor_map.svh ***
// constants for the nibble-swap, xor and direction-load instruction decoder
`ifndef NIBBLE_XOR_MAP_SVH
`define NIBBLE_XOR_MAP_SVH

// opcode fields
`define OPC_SWAP_HI     6'h0E
`define OPC_REG_XOR_HI  6'h06
`define OPC_LIT_XOR_HI  6'h3A
`define OPC_DIRLD_HI    11'h00C
// field positions
`define FLD_DEST_BIT    7
`define FLD_ADDR_MSB    6
// direction register selectors and their file addresses
`define DIR_SEL_MIN     3'h5
`define DIR_SEL_MAX     3'h7
`define DIR_FILE_BASE   7'h05
`define DIR_FILE_OFS    7'h80
// reset values
`define ACC_RESET       8'h00
`define DIR_RESET       8'hFF
`define ZERO_RESET      1'h0

`endif

// *** design/nibble_xor_pkg.sv ***
// types for the nibble-swap, xor and direction-load instruction decoder
package nibble_xor_pkg;

   // decoded operation
   typedef enum logic [2:0]
   {
      OP_NONE     = 3'h0,
      OP_SWAP     = 3'h1,
      OP_XOR_REG  = 3'h3,
      OP_XOR_LIT  = 3'h2,
      OP_DIR_LOAD = 3'h6
   } op_kind_type;

   // request to the register file
   typedef struct packed
   {
      logic       wr_en;
      logic [6:0] addr;
      logic [7:0] data;
   } file_write_type;

endpackage : nibble_xor_pkg

// *** design/nibble_xor_dir_ops.sv ***
// instruction decoder and executor for nibble swap, xor and direction load
`timescale 1ns/10ps
`include "nibble_xor_map.svh"

module nibble_xor_dir_ops
#(
   parameter int DATA_W = 8
)
(
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst,
   // instruction from the fetch path
   input  wire logic                       instr_valid,
   input  wire logic [13:0]                instr_word,
   // file register read port, combinational on instr_word address
   output logic      [6:0]                 file_rd_addr,
   input  wire logic [DATA_W-1:0]          file_rd_data,
   // file register write, one cycle pulse
   output nibble_xor_pkg::file_write_type  file_wr,
   // direction register write from the load op, one cycle pulse
   output logic                            dir_wr_en,
   output logic      [1:0]                 dir_wr_sel,
   output logic      [DATA_W-1:0]          dir_wr_data,
   // core state
   output logic      [DATA_W-1:0]          acc,
   output logic                            zero_flag,
   output logic                            zero_wr,
   output logic                            op_done,
   output nibble_xor_pkg::op_kind_type     op_kind
);

   ////////////////////////////////////////////////////////////////////////////
   // decode

   logic                     dest_bit;
   logic [6:0]               addr_fld;
   logic [DATA_W-1:0]        swapped;
   logic [DATA_W-1:0]        xor_lit;
   logic [DATA_W-1:0]        xor_reg;
   nibble_xor_pkg::op_kind_type op_dec;

   // 7-bit address and one destination bit
   assign dest_bit     = instr_word[`FLD_DEST_BIT];
   assign addr_fld     = instr_word[`FLD_ADDR_MSB:0];
   assign file_rd_addr = addr_fld;
   assign swapped      = {file_rd_data[3:0], file_rd_data[7:4]};
   assign xor_lit      = acc ^ instr_word[7:0];
   assign xor_reg      = acc ^ file_rd_data;

   // opcode match; direction load only accepts selectors 5 to 7
   always_comb
   begin
      op_dec = nibble_xor_pkg::OP_NONE;
      if (instr_valid)
      begin
         if (instr_word[13:8] == `OPC_SWAP_HI)
            op_dec = nibble_xor_pkg::OP_SWAP;
         else if (instr_word[13:8] == `OPC_REG_XOR_HI)
            op_dec = nibble_xor_pkg::OP_XOR_REG;
         else if (instr_word[13:8] == `OPC_LIT_XOR_HI)
            op_dec = nibble_xor_pkg::OP_XOR_LIT;
         // low selectors fall through as a no-op rather than a trap, so
         // old code that happens to use them keeps running
         else if (instr_word[13:3] == `OPC_DIRLD_HI
                  && instr_word[2:0] >= `DIR_SEL_MIN)
            op_dec = nibble_xor_pkg::OP_DIR_LOAD;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // execute: every op retires in the cycle after it is presented

   logic [DATA_W-1:0]              acc_reg,  acc_next;
   logic                           zero_reg, zero_next;
   logic                           zwr_reg,  zwr_next;
   logic                           done_reg, done_next;
   nibble_xor_pkg::op_kind_type    kind_reg, kind_next;
   nibble_xor_pkg::file_write_type fwr_reg,  fwr_next;
   logic                           dwr_reg,  dwr_next;
   logic [1:0]                     dsel_reg, dsel_next;
   logic [DATA_W-1:0]              ddat_reg, ddat_next;

   // next-state computation; only the xor ops touch the zero flag
   always_comb
   begin
      acc_next  = acc_reg;
      zero_next = zero_reg;
      zwr_next  = 1'b0;
      done_next = (op_dec != nibble_xor_pkg::OP_NONE);
      kind_next = op_dec;
      fwr_next  = '0;
      dwr_next  = 1'b0;
      dsel_next = dsel_reg;
      ddat_next = ddat_reg;
      unique case (op_dec)
         nibble_xor_pkg::OP_SWAP:
         begin
            // flags untouched
            if (dest_bit)
               fwr_next = '{wr_en: 1'b1, addr: addr_fld, data: swapped};
            else
               acc_next = swapped;
         end
         nibble_xor_pkg::OP_XOR_REG:
         begin
            zero_next = (xor_reg == '0);
            zwr_next  = 1'b1;
            if (dest_bit)
               fwr_next = '{wr_en: 1'b1, addr: addr_fld, data: xor_reg};
            else
               acc_next = xor_reg;
         end
         nibble_xor_pkg::OP_XOR_LIT:
         begin
            acc_next  = xor_lit;
            zero_next = (xor_lit == '0);
            zwr_next  = 1'b1;
         end
         nibble_xor_pkg::OP_DIR_LOAD:
         begin
            // selector 5..7 maps to 0..2; flags untouched
            dwr_next  = 1'b1;
            dsel_next = 2'(instr_word[2:0] - `DIR_SEL_MIN);
            ddat_next = acc_reg;
         end
         nibble_xor_pkg::OP_NONE:
         begin
            // the same registers are reachable by plain file addressing,
            // so nothing here blocks ordinary writes to them
            fwr_next = '0;
         end
      endcase
   end

   // register stage
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         acc_reg  <= `ACC_RESET;
         zero_reg <= `ZERO_RESET;
         zwr_reg  <= 1'b0;
         done_reg <= 1'b0;
         kind_reg <= nibble_xor_pkg::OP_NONE;
         fwr_reg  <= '0;
         dwr_reg  <= 1'b0;
         dsel_reg <= 2'h0;
         ddat_reg <= `DIR_RESET;
      end
      else
      begin
         acc_reg  <= acc_next;
         zero_reg <= zero_next;
         zwr_reg  <= zwr_next;
         done_reg <= done_next;
         kind_reg <= kind_next;
         fwr_reg  <= fwr_next;
         dwr_reg  <= dwr_next;
         dsel_reg <= dsel_next;
         ddat_reg <= ddat_next;
      end
   end

   assign acc         = acc_reg;
   assign zero_flag   = zero_reg;
   assign zero_wr     = zwr_reg;
   assign op_done     = done_reg;
   assign op_kind     = kind_reg;
   assign file_wr     = fwr_reg;
   assign dir_wr_en   = dwr_reg;
   assign dir_wr_sel  = dsel_reg;
   assign dir_wr_data = ddat_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   // every check but AST_DIR_RANGE and AST_ZERO_FLAG looks one edge after decode, since every output but file_rd_addr is registered;
   // file_rd_data is sampled with the op, so the register file must be combinational

   AST_SWAP_NIBBLES: assert property (@(posedge clk) disable iff (rst)
      op_dec == nibble_xor_pkg::OP_SWAP && !dest_bit
      |=> acc == {$past(file_rd_data[3:0]), $past(file_rd_data[7:4])})
      else $error("swap result wrong");
   AST_SWAP_DEST: assert property (@(posedge clk) disable iff (rst)
      op_dec == nibble_xor_pkg::OP_SWAP
      |=> file_wr.wr_en == $past(dest_bit) && $stable(zero_flag))
      else $error("swap destination or flag wrong");
   AST_SWAP_WRITE: assert property (@(posedge clk) disable iff (rst)
      op_dec == nibble_xor_pkg::OP_SWAP && dest_bit
      |=> file_wr.addr == $past(addr_fld) && $stable(acc)
          && file_wr.data == {$past(file_rd_data[3:0]), $past(file_rd_data[7:4])})
      else $error("swap write-back wrong");
   AST_XOR_LIT: assert property (@(posedge clk) disable iff (rst)
      op_dec == nibble_xor_pkg::OP_XOR_LIT
      |=> acc == ($past(acc) ^ $past(instr_word[7:0])) && !file_wr.wr_en)
      else $error("literal xor wrong");
   AST_XOR_REG: assert property (@(posedge clk) disable iff (rst)
      op_dec == nibble_xor_pkg::OP_XOR_REG && dest_bit
      |=> file_wr.data == ($past(acc) ^ $past(file_rd_data)) && $stable(acc))
      else $error("register xor wrong");
   AST_XOR_REG_W: assert property (@(posedge clk) disable iff (rst)
      op_dec == nibble_xor_pkg::OP_XOR_REG && !dest_bit
      |=> !file_wr.wr_en && acc == ($past(acc) ^ $past(file_rd_data)))
      else $error("register xor to accumulator wrong");
   AST_DIR_LOAD: assert property (@(posedge clk) disable iff (rst)
      op_dec == nibble_xor_pkg::OP_DIR_LOAD
      |=> dir_wr_en && dir_wr_data == $past(acc) && $stable(zero_flag))
      else $error("direction load wrong");
   AST_DIR_RANGE: assert property (@(posedge clk) disable iff (rst)
      dir_wr_en |-> dir_wr_sel != 2'h3)
      else $error("direction selector out of range");
   AST_DIR_SELECT: assert property (@(posedge clk) disable iff (rst)
      op_dec == nibble_xor_pkg::OP_DIR_LOAD
      |=> dir_wr_sel == 2'($past(instr_word[2:0]) - `DIR_SEL_MIN))
      else $error("direction selector mapping wrong");
   // the xor result is in the write-back data when d is set on a register xor, else in the accumulator
   AST_ZERO_FLAG: assert property (@(posedge clk) disable iff (rst)
      zero_wr |-> op_done
         && (zero_flag == ((file_wr.wr_en ? file_wr.data : acc) == '0)))
      else $error("zero flag inconsistent");
   AST_REFUSED_QUIET: assert property (@(posedge clk) disable iff (rst)
      op_dec == nibble_xor_pkg::OP_NONE
      |=> !op_done && !zero_wr && !file_wr.wr_en && !dir_wr_en && $stable(acc))
      else $error("refused word changed state");
   AST_ONE_CYCLE: assert property (@(posedge clk) disable iff (rst)
      instr_valid && op_dec != nibble_xor_pkg::OP_NONE |=> op_done)
      else $error("op did not finish in one cycle");

endmodule : nibble_xor_dir_ops

// *** tb/reg_file_model.sv ***
// register file model answering the decoder's read and write ports
`timescale 1ns/10ps
module reg_file_model
(
   // clock
   input  wire logic                           clk,
   // read port, answered in the same cycle
   input  wire logic [6:0]                     rd_addr,
   output logic      [7:0]                     rd_data,
   // write request from the decoder
   input  wire nibble_xor_pkg::file_write_type wr
);
   logic [7:0] mem [128];

   // known pattern so every expected value can be worked out by hand
   initial
   begin
      for (int i = 0; i < 128; i++)
         mem[i] = 8'hA0 ^ 8'(i);
   end

   // combinational read over the whole 7-bit space
   assign rd_data = mem[rd_addr];

   // direction registers sit here too, written like any other register
   always @(posedge clk)
      if (wr.wr_en)
         mem[wr.addr] <= wr.data;
endmodule : reg_file_model

// *** tb/nibble_xor_dir_ops_tb.sv ***
// self-checking testbench for the nibble-swap, xor and direction-load decoder
`timescale 1ns/10ps
module nibble_xor_dir_ops_tb;
   logic                           clk;
   logic                           rst;
   logic                           instr_valid;
   logic [13:0]                    instr_word;
   logic [6:0]                     file_rd_addr;
   logic [7:0]                     file_rd_data;
   nibble_xor_pkg::file_write_type file_wr;
   logic                           dir_wr_en;
   logic [1:0]                     dir_wr_sel;
   logic [7:0]                     dir_wr_data;
   logic [7:0]                     acc;
   logic                           zero_flag;
   logic                           zero_wr;
   logic                           op_done;
   nibble_xor_pkg::op_kind_type    op_kind;
   int                             n_mismatch;
   int                             num_checks;

   nibble_xor_dir_ops uut (.clk, .rst, .instr_valid, .instr_word, .file_rd_addr,
      .file_rd_data, .file_wr, .dir_wr_en, .dir_wr_sel, .dir_wr_data, .acc,
      .zero_flag, .zero_wr, .op_done, .op_kind);
   reg_file_model rf (.clk(clk), .rd_addr(file_rd_addr), .rd_data(file_rd_data), .wr(file_wr));

   ////////////////////////////////////////////////////////////////////////////////
   // 200 MHz clock
   initial
   begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // offer one word at a falling edge; valid stays up so ops may follow back to back
   task automatic run_op(input logic [13:0] w);
      instr_valid = 1'h1;
      instr_word  = w;
      @(negedge clk);
   endtask : run_op

   // one quiet cycle, lets a pending file write land before the next read
   task automatic idle();
      instr_valid = 1'h0;
      @(negedge clk);
   endtask : idle

   task automatic report_and_stop();
      if (n_mismatch == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop

   ////////////////////////////////////////////////////////////////////////////////
   // flags are packed as {op_done, zero_wr, zero_flag, dir_wr_en}
   task automatic lit_xor_scn();
      run_op(14'h3AB5);
      chk(acc, 8'hB5);
      chk({op_done, zero_wr, zero_flag, dir_wr_en}, 4'hC);
      chk(16'(op_kind), 16'(nibble_xor_pkg::OP_XOR_LIT));
      run_op(14'h3AB5);
      chk({acc, 4'(file_wr.wr_en), op_done, zero_wr, zero_flag, dir_wr_en}, 16'h000E);
      idle();
   endtask : lit_xor_scn

   task automatic swap_scn();
      run_op(14'h0E10);
      chk({acc, 4'(file_wr.wr_en), op_done, zero_wr, zero_flag, dir_wr_en}, 16'h0B0A);
      chk(16'(op_kind), 16'(nibble_xor_pkg::OP_SWAP));
      run_op(14'h0EFF);
      chk(file_wr, 16'hFFFD);
      chk(acc, 8'h0B);
      idle();
   endtask : swap_scn

   task automatic reg_xor_scn();
      run_op(14'h0685);
      chk(file_wr, 16'h85AE);
      chk(file_rd_addr, 7'h05);
      chk({acc, op_done, zero_wr, zero_flag, dir_wr_en}, 12'h0BC);
      chk(16'(op_kind), 16'(nibble_xor_pkg::OP_XOR_REG));
      idle();
      run_op(14'h0605);
      chk({acc, 4'(file_wr.wr_en)}, 12'hA50);
      run_op(14'h0605);
      chk(acc, 8'h0B);
      idle();
   endtask : reg_xor_scn

   // every selector, legal and illegal, back to back
   task automatic dir_load_scn();
      for (int f = 0; f < 8; f++)
      begin
         run_op(14'h0060 | 14'(f));
         if (f >= 5)
         begin
            chk({op_done, zero_wr, zero_flag, dir_wr_en}, 4'h9);
            chk({dir_wr_sel, dir_wr_data}, {2'(f - 5), 8'h0B});
            chk(16'(op_kind), 16'(nibble_xor_pkg::OP_DIR_LOAD));
         end
         else
            chk({acc, op_done, zero_wr, zero_flag, dir_wr_en}, 12'h0B0);
      end
      idle();
   endtask : dir_load_scn

   // unknown word, then a good word without valid, then a reset in mid-run
   task automatic refused_scn();
      run_op(14'h3FFF);
      chk({acc, op_done, zero_wr, zero_flag, dir_wr_en}, 12'h0B0);
      instr_valid = 1'h0;
      instr_word  = 14'h3AFF;
      @(negedge clk);
      chk({acc, op_done, zero_wr, zero_flag, dir_wr_en}, 12'h0B0);
      rst = 1'h1;
      @(negedge clk);
      rst = 1'h0;
      chk({acc, dir_wr_data}, 16'h00FF);
   endtask : refused_scn

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      n_mismatch  = 0;
      num_checks  = 0;
      rst         = 1'h1;
      instr_valid = 1'h0;
      instr_word  = 14'h0000;
      repeat (6) @(negedge clk);
      rst = 1'h0;
      chk({acc, 3'(op_kind), op_done, zero_wr, zero_flag, dir_wr_en}, 15'h0000);
      chk(dir_wr_data, 8'hFF);
      lit_xor_scn();
      swap_scn();
      reg_xor_scn();
      dir_load_scn();
      refused_scn();
      report_and_stop();
   end

   // watchdog against a hung run
   initial
   begin
      repeat (2000) @(posedge clk);
      n_mismatch++;
      report_and_stop();
   end
endmodule : nibble_xor_dir_ops_tb
